// file: inc/mec_pkg.sv
// Constants, register map and shared helpers for the MMU exception check.
// Assumes byte addresses on an 8-bit APB address, 32-bit data words.
`default_nettype none
package mec_pkg;
  localparam int VPN_BITS = 22;
  localparam int PID_BITS = 8;
  localparam int RP_BITS  = 5;
  localparam int PR_W     = 3;
  localparam int CF_W     = 10;
  localparam int APB_AW   = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_PID     = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_INSTR_PAGE_ENTRY_UPPER   = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_DATA_PAGE_ENTRY_UPPER   = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_FCAUSE  = 8'h10;

  // Control register fields
  localparam int CTL_ITE     = 0;
  localparam int CTL_DTE     = 1;
  localparam int CTL_ITE_ON  = 2;
  localparam int CTL_DTE_ON  = 3;
  localparam int CTL_IRP_LSB = 8;
  localparam int CTL_DRP_LSB = 16;

  // Page entry upper: vpn [31:10], pid [7:0]
  localparam int PTEU_VPN_LSB = 10;
  localparam int PTEU_PID_LSB = 0;

  // Fault cause register: two fields
  localparam int FC_IFC_LSB = 0;
  localparam int FC_DFC_LSB = 16;

  // Bits within a cause field
  localparam int CB_MISS   = 0;
  localparam int CB_IW     = 1;
  localparam int CB_INV    = 2;
  localparam int CB_PROT   = 3;
  localparam int CB_LVL    = 4;
  localparam int CB_WR     = 5;
  localparam int CB_PR_LSB = 6;
  localparam int CB_ILL    = 9;
  localparam logic [CF_W-1:0] CF_FAULTS = 10'h20F;

  // Page size codes
  localparam logic [1:0] PS_1K   = 2'b10;
  localparam logic [1:0] PS_4K   = 2'b00;
  localparam logic [1:0] PS_128K = 2'b01;
  localparam logic [1:0] PS_4M   = 2'b11;

  // Enable change settles after this many cycles
  localparam int TE_DELAY_CYC = 2;

  // Reset values
  localparam logic [RP_BITS-1:0]  RP_RESET  = 5'h00;
  localparam logic [PID_BITS-1:0] PID_RESET = 8'h00;

  // Illegal physical ranges
  localparam logic [31:0] I_LOW_TOP  = 32'h03FFFFFF;
  localparam logic [31:0] I_HIGH_BOT = 32'hC0000000;
  localparam logic [31:0] D_LOW_TOP  = 32'h3FFFFFFF;
  localparam logic [31:0] D_MID_BOT  = 32'hC0000000;
  localparam logic [31:0] D_MID_TOP  = 32'hCFFFFFFF;
  localparam logic [31:0] D_HIGH_BOT = 32'hE0000000;

  function automatic logic [VPN_BITS-1:0] vpn_cmp_mask(
    input logic [1:0] ps);
    case (ps)
      PS_1K:   return 22'h3FFFFF;
      PS_4K:   return 22'h3FFFFC;
      PS_128K: return 22'h3FFF80;
      default: return 22'h3FF000;
    endcase
  endfunction

  function automatic logic [31:0] offset_mask(input logic [1:0] ps);
    case (ps)
      PS_1K:   return 32'h000003FF;
      PS_4K:   return 32'h00000FFF;
      PS_128K: return 32'h0001FFFF;
      default: return 32'h003FFFFF;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: logic/mec_tag_match.sv
// Tag comparison of one candidate TLB entry against a lookup.
// Assumes the TLB presents the candidate entry in the same cycle.
`default_nettype none
module mec_tag_match #(
  parameter int VPN_W = mec_pkg::VPN_BITS,
  parameter int PID_W = mec_pkg::PID_BITS
) (
  input  wire logic [VPN_W-1:0] req_vpn,
  input  wire logic [PID_W-1:0] req_pid,
  input  wire logic [VPN_W-1:0] ent_vpn,
  input  wire logic [PID_W-1:0] ent_pid,
  input  wire logic             ent_g,
  input  wire logic [1:0]       ent_ps,
  input  wire logic             ent_valid,
  output logic                  hit
);
  import mec_pkg::*;
  logic [VPN_W-1:0] cmp_mask;
  logic             vpn_eq;
  logic             pid_eq;

  always_comb begin
    cmp_mask = vpn_cmp_mask(ent_ps);
    vpn_eq   = ((req_vpn ^ ent_vpn) & cmp_mask) == '0;
    pid_eq   = ent_g || (req_pid == ent_pid);
    hit      = ent_valid && vpn_eq && pid_eq;
  end
endmodule
`default_nettype wire

// file: logic/mec_check.sv
// MMU exception check: evaluates each translated fetch and data access.
// Assumes the TLB supplies one candidate entry per access on clk.
// Functional notes
// - No match or invalid matching entry raises a TLB miss.
// - Instruction miss: capture vpn and pid, cause 0001, refill pointer, signal.
// - Data miss: capture vpn and pid, cause 0001, refill pointer, signal.
// - Instruction hit: protection fault sets bit 3, absent page bit 2.
// - Instruction hit to illegal physical range sets bit 9.
// - Instruction access fault: capture vpn, pid, cause, hit entry, signal.
// - Data hit: protection fault sets bit 19, absent page bit 18.
// - Permitted write to present unwritten data page sets bit 17.
// - Data hit to illegal physical range sets bit 25.
// - Data access fault: capture vpn, pid, cause, hit entry, signal.
// - Fault cause register holds two 10-bit fields of equal layout.
// - Field bits: 0 miss, 1 initial write, 2 invalid, 3 protection, 9 illegal.
// - Field bit 4 level, bit 5 access type, bits 8:6 protection copy.
// - User read of supervisor-only page is a protection violation.
// - Forbidden user data write flags protection with protection copy.
// - Global entries compare vpn only, others vpn and process id.
// - Compared vpn width follows the page size code.
`default_nettype none
module mec_check #(
  parameter int VPN_W = mec_pkg::VPN_BITS,
  parameter int PID_W = mec_pkg::PID_BITS,
  parameter int RP_W  = mec_pkg::RP_BITS
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [mec_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      if_req,
  input  wire logic [31:0]               if_vaddr,
  input  wire logic                      if_super,
  input  wire logic [VPN_W-1:0]          ient_vpn,
  input  wire logic [PID_W-1:0]          ient_pid,
  input  wire logic                      ient_g,
  input  wire logic [1:0]                ient_ps,
  input  wire logic                      ient_valid,
  input  wire logic [RP_W-1:0]           ient_num,
  input  wire logic [VPN_W-1:0]          ient_ppn,
  input  wire logic [2:0]                ient_pr,
  input  wire logic                      ient_pv,
  input  wire logic                      irefill_done,
  input  wire logic                      d_req,
  input  wire logic [31:0]               d_vaddr,
  input  wire logic                      d_super,
  input  wire logic                      d_write,
  input  wire logic [VPN_W-1:0]          dent_vpn,
  input  wire logic [PID_W-1:0]          dent_pid,
  input  wire logic                      dent_g,
  input  wire logic [1:0]                dent_ps,
  input  wire logic                      dent_valid,
  input  wire logic [RP_W-1:0]           dent_num,
  input  wire logic [VPN_W-1:0]          dent_ppn,
  input  wire logic [2:0]                dent_pr,
  input  wire logic                      dent_pv,
  input  wire logic                      dent_written,
  input  wire logic                      drefill_done,
  output logic                           i_tlb_miss,
  output logic                           i_access_exc,
  output logic                           d_tlb_miss,
  output logic                           d_access_exc
);
  import mec_pkg::*;

  typedef struct packed {
    logic                            instr_translate_enable;
    logic                            data_translate_enable;
    logic [TE_DELAY_CYC-1:0][1:0]    te_pipe;
    logic [RP_W-1:0]                 instr_replace_pointer;
    logic [RP_W-1:0]                 data_replace_pointer;
    logic [PID_W-1:0]                process_id;
    logic [VPN_W-1:0]                ivpn;
    logic [PID_W-1:0]                ipid;
    logic [VPN_W-1:0]                dvpn;
    logic [PID_W-1:0]                dpid;
    logic [CF_W-1:0]                 instr_fault_cause;
    logic [CF_W-1:0]                 dfc;
    logic                            i_miss;
    logic                            i_acc;
    logic                            d_miss;
    logic                            d_acc;
    logic [31:0]                     rdata;
  } mec_state_s;

  mec_state_s      s;
  mec_state_s      next_s;
  logic            i_hit;
  logic            d_hit;
  logic            i_on;
  logic            d_on;
  logic [31:0]     i_pa;
  logic [31:0]     d_pa;
  logic [CF_W-1:0] i_cause;
  logic [CF_W-1:0] d_cause;
  logic            i_fault;
  logic            d_fault;
  logic            addr_ok;
  logic [31:0]     rd_word;

  // Physical address of the mapped access
  function automatic logic [31:0] map_pa(input logic [VPN_W-1:0] ppn,
                                         input logic [31:0] va,
                                         input logic [1:0] ps);
    logic [31:0] off;
    off = offset_mask(ps);
    return ({ppn, 10'h000} & ~off) | (va & off);
  endfunction

  // Access checks shared by both sides
  function automatic logic [CF_W-1:0] eval_access(
    input logic data_side, input logic wr, input logic sup,
    input logic [2:0] pr, input logic pv, input logic written,
    input logic [31:0] pa);
    logic [CF_W-1:0] c;
    logic            ok;
    logic            ill;
    c  = '0;
    ok = sup ? (!wr || pr[2]) : (wr ? pr[0] : pr[1]);
    if (data_side)
      ill = pa <= D_LOW_TOP || (pa >= D_MID_BOT && pa <= D_MID_TOP) ||
            pa >= D_HIGH_BOT;
    else
      ill = pa <= I_LOW_TOP || pa >= I_HIGH_BOT;
    c[CB_LVL]             = sup;
    c[CB_WR]              = wr;
    c[CB_PR_LSB+:PR_W]    = pr;
    c[CB_PROT]            = !ok;
    c[CB_INV]             = !pv;
    c[CB_IW]              = data_side && wr && ok && pv && !written;
    c[CB_ILL]             = ill;
    return c;
  endfunction

  function automatic logic [CF_W-1:0] miss_cause(input logic wr,
                                                 input logic sup);
    logic [CF_W-1:0] c;
    c          = '0;
    c[CB_MISS] = 1'b1;
    c[CB_LVL]  = sup;
    c[CB_WR]   = wr;
    return c;
  endfunction

  mec_tag_match #(.VPN_W(VPN_W), .PID_W(PID_W)) u_imatch (
    .req_vpn   (if_vaddr[31:10]),
    .req_pid   (s.process_id),
    .ent_vpn   (ient_vpn),
    .ent_pid   (ient_pid),
    .ent_g     (ient_g),
    .ent_ps    (ient_ps),
    .ent_valid (ient_valid),
    .hit       (i_hit)
  );

  mec_tag_match #(.VPN_W(VPN_W), .PID_W(PID_W)) u_dmatch (
    .req_vpn   (d_vaddr[31:10]),
    .req_pid   (s.process_id),
    .ent_vpn   (dent_vpn),
    .ent_pid   (dent_pid),
    .ent_g     (dent_g),
    .ent_ps    (dent_ps),
    .ent_valid (dent_valid),
    .hit       (d_hit)
  );

  always_comb begin
    // Enables act only once the delay line has caught up
    i_on    = s.te_pipe[TE_DELAY_CYC-1][0];
    d_on    = s.te_pipe[TE_DELAY_CYC-1][1];
    i_pa    = map_pa(ient_ppn, if_vaddr, ient_ps);
    d_pa    = map_pa(dent_ppn, d_vaddr, dent_ps);
    i_cause = eval_access(1'b0, 1'b0, if_super, ient_pr, ient_pv,
                          1'b1, i_pa);
    d_cause = eval_access(1'b1, d_write, d_super, dent_pr, dent_pv,
                          dent_written, d_pa);
    i_fault = i_hit && |(i_cause & CF_FAULTS);
    d_fault = d_hit && |(d_cause & CF_FAULTS);
    addr_ok = paddr == ADDR_CONTROL || paddr == ADDR_PID ||
              paddr == ADDR_INSTR_PAGE_ENTRY_UPPER || paddr == ADDR_DATA_PAGE_ENTRY_UPPER ||
              paddr == ADDR_FCAUSE;
    rd_word = '0;
    case (paddr)
      ADDR_CONTROL: begin
        rd_word[CTL_ITE]              = s.instr_translate_enable;
        rd_word[CTL_DTE]              = s.data_translate_enable;
        rd_word[CTL_ITE_ON]           = i_on;
        rd_word[CTL_DTE_ON]           = d_on;
        rd_word[CTL_IRP_LSB+:RP_W]    = s.instr_replace_pointer;
        rd_word[CTL_DRP_LSB+:RP_W]    = s.data_replace_pointer;
      end
      ADDR_PID:    rd_word[PTEU_PID_LSB+:PID_W] = s.process_id;
      ADDR_INSTR_PAGE_ENTRY_UPPER: begin
        rd_word[PTEU_VPN_LSB+:VPN_W]  = s.ivpn;
        rd_word[PTEU_PID_LSB+:PID_W]  = s.ipid;
      end
      ADDR_DATA_PAGE_ENTRY_UPPER: begin
        rd_word[PTEU_VPN_LSB+:VPN_W]  = s.dvpn;
        rd_word[PTEU_PID_LSB+:PID_W]  = s.dpid;
      end
      ADDR_FCAUSE: begin
        rd_word[FC_IFC_LSB+:CF_W]     = s.instr_fault_cause;
        rd_word[FC_DFC_LSB+:CF_W]     = s.dfc;
      end
      default:     rd_word = '0;
    endcase
  end

  always_comb begin
    next_s         = s;
    next_s.i_miss  = 1'b0;
    next_s.i_acc   = 1'b0;
    next_s.d_miss  = 1'b0;
    next_s.d_acc   = 1'b0;
    next_s.te_pipe = {s.te_pipe[TE_DELAY_CYC-2:0], {s.data_translate_enable, s.instr_translate_enable}};
    if (irefill_done)
      next_s.instr_replace_pointer = s.instr_replace_pointer + 1'b1;
    if (drefill_done)
      next_s.data_replace_pointer = s.data_replace_pointer + 1'b1;
    // Read data sampled in setup so prdata comes from a flop
    if (psel && !penable && !pwrite)
      next_s.rdata = rd_word;
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_s.instr_translate_enable = pwdata[CTL_ITE];
          next_s.data_translate_enable = pwdata[CTL_DTE];
          next_s.instr_replace_pointer = pwdata[CTL_IRP_LSB+:RP_W];
          next_s.data_replace_pointer = pwdata[CTL_DRP_LSB+:RP_W];
        end
        ADDR_PID:    next_s.process_id = pwdata[PTEU_PID_LSB+:PID_W];
        ADDR_INSTR_PAGE_ENTRY_UPPER: begin
          next_s.ivpn = pwdata[PTEU_VPN_LSB+:VPN_W];
          next_s.ipid = pwdata[PTEU_PID_LSB+:PID_W];
        end
        ADDR_DATA_PAGE_ENTRY_UPPER: begin
          next_s.dvpn = pwdata[PTEU_VPN_LSB+:VPN_W];
          next_s.dpid = pwdata[PTEU_PID_LSB+:PID_W];
        end
        default: ;
      endcase
    end
    // Hardware capture last: it wins over a same-cycle software write
    if (i_on && if_req && (!i_hit || i_fault)) begin
      next_s.ivpn = if_vaddr[31:10];
      next_s.ipid = s.process_id;
      if (!i_hit) begin
        next_s.instr_fault_cause    = miss_cause(1'b0, if_super);
        next_s.instr_replace_pointer    = s.instr_replace_pointer;
        next_s.i_miss = 1'b1;
      end else begin
        next_s.instr_fault_cause    = i_cause;
        next_s.instr_replace_pointer    = ient_num;
        next_s.i_acc  = 1'b1;
      end
    end
    if (d_on && d_req && (!d_hit || d_fault)) begin
      next_s.dvpn = d_vaddr[31:10];
      next_s.dpid = s.process_id;
      if (!d_hit) begin
        next_s.dfc    = miss_cause(d_write, d_super);
        next_s.data_replace_pointer    = s.data_replace_pointer;
        next_s.d_miss = 1'b1;
      end else begin
        next_s.dfc    = d_cause;
        next_s.data_replace_pointer    = dent_num;
        next_s.d_acc  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s     <= '0;
      s.instr_replace_pointer <= RP_RESET;
      s.data_replace_pointer <= RP_RESET;
      s.process_id <= PID_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave: every access completes in its first access cycle
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !addr_ok;
  assign prdata       = s.rdata;
  assign i_tlb_miss   = s.i_miss;
  assign i_access_exc = s.i_acc;
  assign d_tlb_miss   = s.d_miss;
  assign d_access_exc = s.d_acc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_imiss_cause: assert property (
    i_on && if_req && !i_hit |=> i_tlb_miss && s.instr_fault_cause[3:0] == 4'b0001 &&
    s.ivpn == $past(if_vaddr[31:10]))
    else $error("instr miss not captured");
  a_dmiss_cause: assert property (
    d_on && d_req && !d_hit |=> d_tlb_miss && s.dfc[3:0] == 4'b0001
    && s.data_replace_pointer == $past(s.data_replace_pointer))
    else $error("data miss not captured");
  a_one_exc: assert property (
    !(i_tlb_miss && i_access_exc) && !(d_tlb_miss && d_access_exc))
    else $error("two exceptions for one access");
  a_iprot_flag: assert property (
    i_on && if_req && i_hit && !if_super && !ient_pr[1] |=>
    i_access_exc && s.instr_fault_cause[CB_PROT])
    else $error("instr protection fault missed");
  a_iinv_flag: assert property (
    i_on && if_req && i_hit && !ient_pv |=> i_access_exc && s.instr_fault_cause[CB_INV])
    else $error("instr page invalid missed");
  a_iill_flag: assert property (
    i_on && if_req && i_hit && i_pa >= I_HIGH_BOT |=> s.instr_fault_cause[CB_ILL])
    else $error("instr illegal address missed");
  a_iacc_entry: assert property (
    i_on && if_req && i_fault |=> s.instr_replace_pointer == $past(ient_num) &&
    s.ipid == $past(s.process_id))
    else $error("instr fault entry not recorded");
  a_dprot_flag: assert property (
    d_on && d_req && d_hit && !d_super && d_write && !dent_pr[0] |=>
    d_access_exc && s.dfc[CB_PROT] && s.dfc[CB_WR])
    else $error("data protection fault missed");
  a_dinit_write: assert property (
    d_on && d_req && d_hit && d_super && d_write && dent_pr[2] &&
    dent_pv && !dent_written |=> d_access_exc && s.dfc[CB_IW])
    else $error("initial write missed");
  a_dill_flag: assert property (
    d_on && d_req && d_hit && d_pa <= D_LOW_TOP |=> s.dfc[CB_ILL])
    else $error("data illegal address missed");
  a_dpr_copy: assert property (
    d_on && d_req && d_fault |=> s.dfc[8:6] == $past(dent_pr) &&
    s.dfc[CB_LVL] == $past(d_super))
    else $error("data cause fields wrong");
  a_global_match: assert property (
    d_on && d_req && dent_valid && dent_g && dent_ps == PS_1K &&
    d_vaddr[31:10] == dent_vpn |=> !d_tlb_miss)
    else $error("global entry missed");
  a_enable_delay: assert property (
    $rose(s.instr_translate_enable) |-> !i_on ##1 !i_on ##1 i_on)
    else $error("enable delay wrong");

  c_imiss: cover property (i_tlb_miss);
  c_dinit: cover property (d_access_exc && s.dfc[CB_IW]);
  c_both: cover property (i_access_exc && d_tlb_miss);
  c_apb_err: cover property (pslverr);
endmodule
`default_nettype wire

// file: testbench/mec_cpu_model.sv
// Behavioural CPU core and miss handler facing the exception check.
// Assumes one-cycle miss pulses on the shared core clock.
`default_nettype none
module mec_cpu_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic i_tlb_miss,
  input  wire logic d_tlb_miss,
  output var  logic irefill_done,
  output var  logic drefill_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // Handler refill finishes one cycle after the miss; quicker than software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irefill_done <= 1'b0;
      drefill_done <= 1'b0;
    end else begin
      irefill_done <= i_tlb_miss;
      drefill_done <= d_tlb_miss;
    end
  end
endmodule
`default_nettype wire

// file: testbench/mec_check_tb.sv
// Self-checking bench: APB register access and TLB lookup checks.
// Assumes zero-wait APB slave and one-cycle exception pulses.
`default_nettype none
module mec_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mec_pkg::*;
  localparam logic [7:0] PIDV = 8'h5A;
  logic        clk, reset_n, psel, penable, pwrite, if_req, d_req;
  logic        sup, wr, e_g, e_valid, e_pv, e_wt;
  logic        pready, pslverr, irefill_done, drefill_done;
  logic        i_tlb_miss, i_access_exc, d_tlb_miss, d_access_exc;
  logic [7:0]  paddr, e_pid;
  logic [31:0] pwdata, prdata, va;
  logic [21:0] e_vpn, e_ppn;
  logic [1:0]  e_ps;
  logic [4:0]  e_num;
  logic [2:0]  e_pr;
  int          num_errors = 0;
  int          checks_done = 0;

  mec_check mec_check_inst (
    .clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .if_req, .if_vaddr(va), .if_super(sup),
    .ient_vpn(e_vpn), .ient_pid(e_pid), .ient_g(e_g), .ient_ps(e_ps),
    .ient_valid(e_valid), .ient_num(e_num), .ient_ppn(e_ppn),
    .ient_pr(e_pr), .ient_pv(e_pv), .irefill_done, .d_req,
    .d_vaddr(va), .d_super(sup), .d_write(wr), .dent_vpn(e_vpn),
    .dent_pid(e_pid), .dent_g(e_g), .dent_ps(e_ps), .dent_valid(e_valid),
    .dent_num(e_num), .dent_ppn(e_ppn), .dent_pr(e_pr), .dent_pv(e_pv),
    .dent_written(e_wt), .drefill_done, .i_tlb_miss, .i_access_exc,
    .d_tlb_miss, .d_access_exc
  );
  mec_cpu_model mec_cpu_model_inst (
    .clk, .reset_n, .i_tlb_miss, .d_tlb_miss, .irefill_done, .drefill_done
  );

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
  endtask

  // Matching 1K entry for the address built from vpn
  task automatic ent(input logic [21:0] virtual_page_number, input logic [21:0] ppn,
                     input logic [2:0] pr, input logic pv, input logic wt,
                     input logic s, input logic w);
    va <= {virtual_page_number, 10'h000};
    e_vpn <= virtual_page_number;
    e_ppn <= ppn;
    e_pr <= pr;
    e_pv <= pv;
    e_wt <= wt;
    sup <= s;
    wr <= w;
    e_valid <= 1'b1;
    e_g <= 1'b0;
    e_ps <= PS_1K;
    e_pid <= PIDV;
    e_num <= 5'h03;
  endtask

  // ex order: i miss, i access, d miss, d access
  task automatic fire(input logic d, input logic [3:0] ex,
                      input logic [9:0] cf);
    logic [31:0] v;
    @(posedge clk);
    if_req <= !d;
    d_req <= d;
    @(posedge clk);
    if_req <= 1'b0;
    d_req <= 1'b0;
    // Pulse launched at the last edge still stands at this one
    @(posedge clk);
    chk({28'h0, i_tlb_miss, i_access_exc, d_tlb_miss, d_access_exc},
        {28'h0, ex});
    if (ex != 4'h0) begin
      rdr(ADDR_FCAUSE, v);
      chk({22'h0, d ? v[25:16] : v[9:0]}, {22'h0, cf});
      rdr(d ? ADDR_DATA_PAGE_ENTRY_UPPER : ADDR_INSTR_PAGE_ENTRY_UPPER, v);
      chk(v, {va[31:10], 2'b00, PIDV});
    end
  endtask

  task automatic t_reset();
    logic [31:0] v;
    logic        e;
    for (int i = 0; i < 5; i++) begin
      rdr(8'(4 * i), v);
      chk(v, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    wrr(ADDR_FCAUSE, 32'hFFFFFFFF);
    rdr(ADDR_FCAUSE, v);
    chk(v, 32'h0);
    ent(22'h100000, 22'h10000, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    fire(1'b0, 4'h0, 10'h000);
    fire(1'b1, 4'h0, 10'h000);
    $display("t_reset done");
  endtask

  task automatic t_enable();
    logic [31:0] v;
    wrr(ADDR_PID, {24'h0, PIDV});
    wrr(ADDR_CONTROL, 32'h3);
    repeat (TE_DELAY_CYC) @(posedge clk);
    rdr(ADDR_CONTROL, v);
    chk({28'h0, v[3:0]}, 32'hF);
    $display("t_enable done");
  endtask

  task automatic t_miss();
    logic [31:0] v;
    ent(22'h048D1, 22'h10000, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    e_valid <= 1'b0;
    fire(1'b0, 4'h8, 10'h001);
    ent(22'h100000, 22'h100000, 3'h7, 1'b1, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    e_pid <= PIDV ^ 8'h01;
    fire(1'b1, 4'h2, 10'h021);
    e_g <= 1'b1;
    fire(1'b1, 4'h0, 10'h000);
    rdr(ADDR_CONTROL, v);
    chk({27'h0, v[12:8]}, 32'h1);
    chk({27'h0, v[20:16]}, 32'h1);
    $display("t_miss done");
  endtask

  task automatic t_size();
    ent(22'h100000, 22'h10000, 3'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    e_ps <= PS_4M;
    va <= 32'h403FFC00;
    fire(1'b0, 4'h0, 10'h000);
    e_ps <= PS_4K;
    va <= {22'h100001, 10'h000};
    fire(1'b0, 4'h0, 10'h000);
    va <= {22'h100004, 10'h000};
    fire(1'b0, 4'h8, 10'h011);
    e_ps <= PS_1K;
    va <= {22'h100001, 10'h000};
    fire(1'b0, 4'h8, 10'h011);
    $display("t_size done");
  endtask

  task automatic t_iacc();
    logic [31:0] v;
    ent(22'h100000, 22'h10000, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    e_num <= 5'h05;
    fire(1'b0, 4'h4, 10'h008);
    rdr(ADDR_CONTROL, v);
    chk({27'h0, v[12:8]}, 32'h5);
    ent(22'h100000, 22'h10000, 3'h4, 1'b1, 1'b1, 1'b0, 1'b0);
    fire(1'b0, 4'h4, 10'h108);
    ent(22'h100000, 22'h10000, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    fire(1'b0, 4'h4, 10'h014);
    ent(22'h100000, 22'h00FFF, 3'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    fire(1'b0, 4'h4, 10'h210);
    e_ppn <= 22'h300000;
    fire(1'b0, 4'h4, 10'h210);
    e_ppn <= 22'h2FFFFF;
    fire(1'b0, 4'h0, 10'h000);
    $display("t_iacc done");
  endtask

  task automatic t_dacc();
    logic [31:0] v;
    ent(22'h100000, 22'h100000, 3'h4, 1'b1, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    e_num <= 5'h09;
    fire(1'b1, 4'h1, 10'h128);
    rdr(ADDR_CONTROL, v);
    chk({27'h0, v[20:16]}, 32'h9);
    e_pr <= 3'h0;
    fire(1'b1, 4'h1, 10'h028);
    e_pr <= 3'h6;
    fire(1'b1, 4'h1, 10'h1A8);
    ent(22'h100000, 22'h100000, 3'h4, 1'b1, 1'b0, 1'b1, 1'b1);
    fire(1'b1, 4'h1, 10'h132);
    ent(22'h100000, 22'h300000, 3'h4, 1'b1, 1'b1, 1'b1, 1'b0);
    fire(1'b1, 4'h1, 10'h310);
    e_ppn <= 22'h340000;
    fire(1'b1, 4'h0, 10'h000);
    e_ppn <= 22'h380000;
    fire(1'b1, 4'h1, 10'h310);
    e_ppn <= 22'h0FFFFF;
    fire(1'b1, 4'h1, 10'h310);
    ent(22'h100000, 22'h100000, 3'h4, 1'b0, 1'b1, 1'b1, 1'b0);
    fire(1'b1, 4'h1, 10'h114);
    $display("t_dacc done");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {reset_n, psel, penable, pwrite, if_req, d_req, sup, wr} = 8'h00;
    {e_g, e_valid, e_pv, e_wt, paddr, e_pid, pwdata, va} = 84'h0;
    {e_vpn, e_ppn, e_ps, e_num, e_pr} = 54'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_enable();
    t_miss();
    t_size();
    t_iacc();
    t_dacc();
    give_verdict();
  end

  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
